// [rtl/tlbc_map.svh]
// tlbc_map.svh: offsets, field positions, reset values and page shifts of the translation buffer.
// assumes: included by the top module, the monitor and the testbench; register data is 32 bits over APB.
`ifndef TLBC_MAP_SVH
`define TLBC_MAP_SVH

// register byte offsets
`define TLBC_CTRL_OFF      12'h000
`define TLBC_STATUS_OFF    12'h004
`define TLBC_OPERAND_OFF   12'h008
`define TLBC_OPERAND_HI    12'h00C
`define TLBC_INVCMD_OFF    12'h010
`define TLBC_VIRTUAL_MACHINE_IDENTIFIER_OFF      12'h014
`define TLBC_HITCNT_OFF    12'h018
`define TLBC_MISSCNT_OFF   12'h01C

// control register fields
`define TLBC_CTRL_EN_BIT   0
`define TLBC_CTRL_RST      32'h0000_0001

// invalidate command register fields
`define TLBC_INV_TYPE_LSB  0
`define TLBC_INV_LVL_LSB   4
`define TLBC_INV_IS_BIT    6
`define TLBC_INV_LAST_BIT  7

// page shifts per entry size
`define TLBC_SHIFT_4K      6'd12
`define TLBC_SHIFT_16K     6'd14
`define TLBC_SHIFT_64K     6'd16
`define TLBC_SHIFT_2M      6'd21
`define TLBC_SHIFT_32M     6'd25
`define TLBC_SHIFT_512M    6'd29
`define TLBC_SHIFT_1G      6'd30

`endif

// [rtl/tlbc_pkg.sv]
// tlbc_pkg.sv: types shared by the translation buffer.
// assumes: 48-bit addresses, 16-bit identifiers.
package tlbc_pkg;

    typedef enum logic [3:0] {
        TLBC_INV_ALL    = 4'b0000,
        TLBC_INV_ADDRESS_SPACE_IDENTIFIER   = 4'b0001,
        TLBC_INV_VA     = 4'b0010,
        TLBC_INV_VAA    = 4'b0011,
        TLBC_INV_VM1    = 4'b0100,
        TLBC_INV_VM12   = 4'b0101,
        TLBC_INV_IPA    = 4'b0110
    } tlbc_inv_t;

    typedef enum logic [1:0] {
        TLBC_ST_IDLE = 2'b00,
        TLBC_ST_WALK = 2'b01,
        TLBC_ST_FILL = 2'b10
    } tlbc_state_t;

    typedef enum logic [1:0] {
        TLBC_GR_4K  = 2'b00,
        TLBC_GR_16K = 2'b01,
        TLBC_GR_64K = 2'b11
    } tlbc_gran_t;

    typedef struct packed {
        logic        valid;
        logic [47:0] va;
        logic [47:0] pa;
        logic [5:0]  shift;
        logic [7:0]  mem_attr;
        logic [1:0]  perm;
        logic [15:0] address_space_identifier;
        logic [15:0] virtual_machine_identifier;
        logic [1:0]  el;
        logic        stage2;
        logic        global;
        logic        inner_sh;
        logic        last_lvl;
    } tlbc_entry_t;

    typedef struct packed {
        logic [47:0] pa;
        logic [7:0]  mem_attr;
        logic [1:0]  perm;
        logic [1:0]  level;
        tlbc_gran_t  gran;
        logic        block;
        logic        contig;
        logic        inner_sh;
        logic        global;
        logic        fault;
    } tlbc_walk_t;

    typedef struct packed {
        tlbc_inv_t   kind;
        logic [1:0]  el;
        logic        inner_sh;
        logic        last_only;
    } tlbc_cmd_t;

endpackage : tlbc_pkg

// [rtl/tlbc_top.sv]
// tlbc_top.sv: translation lookaside buffer with walk refill and invalidate engine.
// assumes: core holds lookup request until lkp_ack; walker answers once per walk_req.
`timescale 1ns/1ns
`include "tlbc_map.svh"

module tlbc_top
    import tlbc_pkg::*;
#(
    parameter int ENTRIES = 16
) (
    input  wire logic        clk,          // 100 MHz clock
    input  wire logic        nrst,         // sync reset, active low
    // apb slave
    input  wire logic        psel,         // select
    input  wire logic        penable,      // access phase
    input  wire logic        pwrite,       // write
    input  wire logic [11:0] paddr,        // byte address
    input  wire logic [31:0] pwdata,       // write data
    output logic      [31:0] prdata,       // read data
    output logic             pready,       // ready
    output logic             pslverr,      // error
    // lookup from core
    input  wire logic        lkp_req,      // lookup request level
    input  wire logic [47:0] lkp_va,       // virtual address
    input  wire logic [15:0] lkp_address_space_identifier,     // address space identifier
    input  wire logic [1:0]  lkp_el,       // privilege level
    output logic             lkp_ack,      // answer pulse
    output logic      [47:0] lkp_pa,       // physical address
    output logic      [7:0]  lkp_attr,     // memory type and cache policy
    output logic      [1:0]  lkp_perm,     // access permissions
    output logic             lkp_fault,    // translation fault
    output logic             lkp_hit,      // answered from buffer
    // table walker
    output logic             walk_req,     // walk request level
    output logic      [47:0] walk_va,      // address to walk
    input  wire logic        walk_done,    // walk result pulse
    input  wire tlbc_walk_t  walk_res      // walk result
);

    tlbc_entry_t       ent_q [ENTRIES];
    logic [$clog2(ENTRIES)-1:0] rr_q;
    tlbc_state_t       st_q;
    logic [31:0]       ctrl_q;
    logic [47:0]       opnd_q;
    logic [15:0]       virtual_machine_identifier_q;
    logic [31:0]       hits_q;
    logic [31:0]       miss_q;
    logic              inv_pend_q;
    tlbc_cmd_t         cmd_q;
    logic              busy_q;

    logic              apb_wr;
    logic              hit;
    logic [ENTRIES-1:0] hit_vec;
    tlbc_entry_t       hit_ent;
    logic [47:0]       mask_hit;
    logic [5:0]        fill_shift;

    function automatic logic [47:0] lowmask(input logic [5:0] sh);
        lowmask = (48'h0000_0000_0001 << sh) - 48'h0000_0000_0001;
    endfunction : lowmask

    function automatic logic [15:0] cmd_address_space_identifier(input logic [47:0] op);
        cmd_address_space_identifier = op[47:32];
    endfunction : cmd_address_space_identifier

    assign apb_wr  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        hit_vec = '0;
        hit_ent = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (ent_q[i].valid && !ent_q[i].stage2 && ent_q[i].el == lkp_el &&
                (ent_q[i].global || ent_q[i].address_space_identifier == lkp_address_space_identifier) &&
                ent_q[i].virtual_machine_identifier == virtual_machine_identifier_q &&
                ((ent_q[i].va ^ lkp_va) & ~lowmask(ent_q[i].shift)) == 48'h0) begin
                hit_vec[i] = 1'b1;
            end
        end
        // first match only, multi-hit never merges permissions
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_ent = ent_q[i];
            end
        end
    end
    assign hit      = ctrl_q[`TLBC_CTRL_EN_BIT] && (hit_vec != '0);
    assign mask_hit = lowmask(hit_ent.shift);

    // entry size from granule and level
    always_comb begin
        fill_shift = `TLBC_SHIFT_4K;
        case (walk_res.gran)
            TLBC_GR_4K: begin
                if (walk_res.level == 2'd3) begin
                    fill_shift = walk_res.contig ? `TLBC_SHIFT_64K : `TLBC_SHIFT_4K;
                end else begin
                    fill_shift = `TLBC_SHIFT_2M;
                end
            end
            TLBC_GR_16K: begin
                if (walk_res.level == 2'd3) begin
                    fill_shift = walk_res.contig ? `TLBC_SHIFT_2M : `TLBC_SHIFT_16K;
                end else begin
                    fill_shift = walk_res.contig ? `TLBC_SHIFT_1G : `TLBC_SHIFT_32M;
                end
            end
            TLBC_GR_64K: begin
                if (walk_res.level == 2'd3) begin
                    fill_shift = walk_res.contig ? `TLBC_SHIFT_2M : `TLBC_SHIFT_64K;
                end else begin
                    fill_shift = `TLBC_SHIFT_512M;
                end
            end
            default: fill_shift = `TLBC_SHIFT_4K;
        endcase
    end

    // lookup and walk sequencing
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q      <= TLBC_ST_IDLE;
            lkp_ack   <= 1'b0;
            lkp_pa    <= 48'h0;
            lkp_attr  <= 8'h00;
            lkp_perm  <= 2'b00;
            lkp_fault <= 1'b0;
            lkp_hit   <= 1'b0;
            walk_req  <= 1'b0;
            walk_va   <= 48'h0;
        end else begin
            lkp_ack <= 1'b0;
            case (st_q)
                TLBC_ST_IDLE: begin
                    // a lookup must not see entries that an invalidate is clearing
                    if (lkp_req && !lkp_ack && !busy_q && !inv_pend_q) begin
                        if (hit) begin
                            lkp_ack   <= 1'b1;
                            lkp_hit   <= 1'b1;
                            lkp_fault <= 1'b0;
                            lkp_pa    <= (hit_ent.pa & ~mask_hit) | (lkp_va & mask_hit);
                            lkp_attr  <= hit_ent.mem_attr;
                            lkp_perm  <= hit_ent.perm;
                        end else begin
                            walk_req <= 1'b1;
                            walk_va  <= lkp_va;
                            st_q     <= TLBC_ST_WALK;
                        end
                    end
                end
                TLBC_ST_WALK: begin
                    if (walk_done) begin
                        walk_req  <= 1'b0;
                        lkp_ack   <= 1'b1;
                        lkp_hit   <= 1'b0;
                        lkp_fault <= walk_res.fault;
                        lkp_pa    <= (walk_res.pa & ~lowmask(fill_shift)) |
                                     (walk_va & lowmask(fill_shift));
                        lkp_attr  <= walk_res.mem_attr;
                        lkp_perm  <= walk_res.perm;
                        st_q      <= TLBC_ST_FILL;
                    end
                end
                TLBC_ST_FILL: begin
                    st_q <= TLBC_ST_IDLE;
                end
                default: st_q <= TLBC_ST_IDLE;
            endcase
        end
    end

    // entry storage, refill and invalidation
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_q[i] <= '0;
            end
            rr_q <= '0;
        end else if (inv_pend_q) begin
            for (int i = 0; i < ENTRIES; i++) begin
                logic sel;
                logic am;
                sel = 1'b0;
                am  = ((ent_q[i].va ^ opnd_q) & ~lowmask(ent_q[i].shift)) == 48'h0;
                case (cmd_q.kind)
                    TLBC_INV_ALL:  sel = ent_q[i].el == cmd_q.el;
                    TLBC_INV_ADDRESS_SPACE_IDENTIFIER: sel = !ent_q[i].stage2 &&
                                         ent_q[i].address_space_identifier == cmd_address_space_identifier(opnd_q);
                    TLBC_INV_VA:   sel = !ent_q[i].stage2 && am && ent_q[i].el == cmd_q.el &&
                                         (ent_q[i].global || ent_q[i].address_space_identifier == cmd_address_space_identifier(opnd_q));
                    TLBC_INV_VAA:  sel = !ent_q[i].stage2 && am;
                    TLBC_INV_VM1:  sel = !ent_q[i].stage2 && ent_q[i].virtual_machine_identifier == virtual_machine_identifier_q &&
                                         ent_q[i].el == 2'd1;
                    TLBC_INV_VM12: sel = ent_q[i].virtual_machine_identifier == virtual_machine_identifier_q;
                    TLBC_INV_IPA:  sel = ent_q[i].stage2 && am && ent_q[i].virtual_machine_identifier == virtual_machine_identifier_q;
                    default:       sel = 1'b0;
                endcase
                if (cmd_q.inner_sh && !ent_q[i].inner_sh) begin
                    sel = 1'b0;
                end
                if (cmd_q.last_only && !ent_q[i].last_lvl) begin
                    sel = 1'b0;
                end
                if (sel) begin
                    ent_q[i].valid <= 1'b0;
                end
            end
        end else if (st_q == TLBC_ST_WALK && walk_done && !walk_res.fault &&
                     ctrl_q[`TLBC_CTRL_EN_BIT]) begin
            // fill only without fault, full entry content
            ent_q[rr_q].valid    <= 1'b1;
            ent_q[rr_q].va       <= walk_va & ~lowmask(fill_shift);
            ent_q[rr_q].pa       <= walk_res.pa & ~lowmask(fill_shift);
            ent_q[rr_q].shift    <= fill_shift;
            ent_q[rr_q].mem_attr <= walk_res.mem_attr;
            ent_q[rr_q].perm     <= walk_res.perm;
            ent_q[rr_q].address_space_identifier     <= lkp_address_space_identifier;
            ent_q[rr_q].virtual_machine_identifier     <= virtual_machine_identifier_q;
            ent_q[rr_q].el       <= lkp_el;
            ent_q[rr_q].stage2   <= 1'b0;
            ent_q[rr_q].global   <= walk_res.global;
            ent_q[rr_q].inner_sh <= walk_res.inner_sh;
            ent_q[rr_q].last_lvl <= walk_res.level == 2'd3 || walk_res.block;
            rr_q <= rr_q + 1'b1;
        end
    end

    // register writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q     <= `TLBC_CTRL_RST;
            opnd_q     <= 48'h0;
            virtual_machine_identifier_q     <= 16'h0000;
            cmd_q      <= '0;
            inv_pend_q <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            inv_pend_q <= 1'b0;
            busy_q     <= inv_pend_q;
            if (apb_wr) begin
                case (paddr)
                    `TLBC_CTRL_OFF:    ctrl_q <= pwdata;
                    `TLBC_OPERAND_OFF: opnd_q[31:0] <= pwdata;
                    `TLBC_OPERAND_HI:  opnd_q[47:32] <= pwdata[15:0];
                    `TLBC_VIRTUAL_MACHINE_IDENTIFIER_OFF:    virtual_machine_identifier_q <= pwdata[15:0];
                    `TLBC_INVCMD_OFF: begin
                        cmd_q.kind      <= tlbc_inv_t'(pwdata[`TLBC_INV_TYPE_LSB +: 4]);
                        cmd_q.el        <= pwdata[`TLBC_INV_LVL_LSB +: 2];
                        cmd_q.inner_sh  <= pwdata[`TLBC_INV_IS_BIT];
                        cmd_q.last_only <= pwdata[`TLBC_INV_LAST_BIT];
                        inv_pend_q      <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // counters
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hits_q <= 32'h0000_0000;
            miss_q <= 32'h0000_0000;
        end else if (st_q == TLBC_ST_IDLE && lkp_req && !lkp_ack && !busy_q &&
                     !inv_pend_q) begin
            if (hit) begin
                hits_q <= hits_q + 32'h0000_0001;
            end else begin
                miss_q <= miss_q + 32'h0000_0001;
            end
        end
    end

    // register reads
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                `TLBC_CTRL_OFF:    prdata = ctrl_q;
                `TLBC_STATUS_OFF:  prdata = {29'h0, inv_pend_q | busy_q, st_q};
                `TLBC_OPERAND_OFF: prdata = opnd_q[31:0];
                `TLBC_OPERAND_HI:  prdata = {16'h0000, opnd_q[47:32]};
                `TLBC_VIRTUAL_MACHINE_IDENTIFIER_OFF:    prdata = {16'h0000, virtual_machine_identifier_q};
                `TLBC_HITCNT_OFF:  prdata = hits_q;
                `TLBC_MISSCNT_OFF: prdata = miss_q;
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule : tlbc_top

// [tb/tlbc_monitor.sv]
// tlbc_monitor.sv: port assertions for the translation buffer.
// assumes: bound into tlbc_top; one clock, synchronous active-low reset.
`timescale 1ns/1ns
`include "tlbc_map.svh"
module tlbc_monitor
    import tlbc_pkg::*;
#(
    parameter int ENTRIES = 16
) (
    input wire logic        clk,       // clock
    input wire logic        nrst,      // reset
    input wire logic        psel,      // apb
    input wire logic        penable,   // apb
    input wire logic        pwrite,    // apb
    input wire logic [11:0] paddr,     // apb
    input wire logic [31:0] pwdata,    // apb
    input wire logic [31:0] prdata,    // apb
    input wire logic        pready,    // apb
    input wire logic        pslverr,   // apb
    input wire logic        lkp_req,   // lookup
    input wire logic [47:0] lkp_va,    // lookup
    input wire logic [15:0] lkp_address_space_identifier,  // lookup
    input wire logic [1:0]  lkp_el,    // lookup
    input wire logic        lkp_ack,   // answer
    input wire logic [47:0] lkp_pa,    // answer
    input wire logic [7:0]  lkp_attr,  // answer
    input wire logic [1:0]  lkp_perm,  // answer
    input wire logic        lkp_fault, // answer
    input wire logic        lkp_hit,   // answer
    input wire logic        walk_req,  // walker
    input wire logic [47:0] walk_va,   // walker
    input wire logic        walk_done, // walker
    input wire tlbc_walk_t  walk_res   // walker
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    hit_no_walk_a: assert property (
        lkp_ack && lkp_hit |-> !$past(walk_req)) else $error("hit answered after a walk");
    hit_offset_a: assert property (
        lkp_ack && lkp_hit |-> lkp_pa[11:0] == $past(lkp_va[11:0]))
        else $error("page offset lost on hit");
    ack_pulse_a: assert property (
        lkp_ack |=> !lkp_ack) else $error("answer longer than one cycle");
    req_served_a: assert property (
        $rose(lkp_req) |-> ##[1:40] (lkp_ack || walk_req)) else $error("lookup not served");
    miss_walks_a: assert property (
        $rose(walk_req) |-> lkp_req && walk_va[47:12] == lkp_va[47:12])
        else $error("walk address wrong");
    walk_hold_a: assert property (
        walk_req && !walk_done |=> walk_req && $stable(walk_va)) else $error("walk dropped");
    walk_end_a: assert property (
        walk_done |=> !walk_req) else $error("walk request after result");
    walk_answer_a: assert property (
        walk_done && walk_req |=> lkp_ack && !lkp_hit && lkp_fault == $past(walk_res.fault))
        else $error("walk result not answered");
    walk_attr_a: assert property (
        walk_done && walk_req && !walk_res.fault |=> lkp_attr == $past(walk_res.mem_attr)
        && lkp_perm == $past(walk_res.perm)) else $error("walk attributes lost");
    inv_stall_a: assert property (
        psel && penable && pwrite && paddr == `TLBC_INVCMD_OFF
        |-> ##2 !(lkp_ack && lkp_hit) ##1 !(lkp_ack && lkp_hit))
        else $error("lookup hit during invalidate");

    cover_hit: cover property (lkp_ack && lkp_hit);
    cover_miss: cover property (lkp_ack && !lkp_hit && !lkp_fault);
    cover_fault: cover property (lkp_ack && lkp_fault);
endmodule : tlbc_monitor

bind tlbc_top tlbc_monitor #(.ENTRIES(ENTRIES)) u_mon (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lkp_req(lkp_req), .lkp_va(lkp_va), .lkp_address_space_identifier(lkp_address_space_identifier), .lkp_el(lkp_el),
    .lkp_ack(lkp_ack), .lkp_pa(lkp_pa), .lkp_attr(lkp_attr), .lkp_perm(lkp_perm),
    .lkp_fault(lkp_fault), .lkp_hit(lkp_hit), .walk_req(walk_req), .walk_va(walk_va),
    .walk_done(walk_done), .walk_res(walk_res)
);

// [tb/tlbc_walker.sv]
// tlbc_walker.sv: behavioural table walker answering walk requests.
// assumes: one walk at a time; descriptor template set by the testbench.
`timescale 1ns/1ns
module tlbc_walker
    import tlbc_pkg::*;
(
    input  wire logic        clk,       // clock
    input  wire logic        nrst,      // sync reset, active low
    input  wire logic        walk_req,  // walk request level
    input  wire logic [47:0] walk_va,   // address to walk
    input  wire logic [7:0]  dly,       // cycles to answer, at least 1
    input  wire tlbc_walk_t  cfg,       // descriptor template
    output logic             walk_done, // result pulse
    output tlbc_walk_t       walk_res   // result
);
    logic [7:0] cnt_q;
    logic       busy_q;
    tlbc_walk_t res;

    always_comb begin
        res    = cfg;
        res.pa = walk_va + 48'h0100_0000_0000;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q     <= 8'h00;
            busy_q    <= 1'b0;
            walk_done <= 1'b0;
            walk_res  <= '0;
        end else begin
            walk_done <= 1'b0;
            // result lines toggle outside the answer cycle
            walk_res  <= ~walk_res;
            if (!walk_req) begin
                busy_q <= 1'b0;
            end else if (!busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= dly;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    walk_done <= 1'b1;
                    walk_res  <= res;
                end
            end
        end
    end
endmodule : tlbc_walker

// [tb/translation_lookaside_buffer_tb.sv]
// translation_lookaside_buffer_tb.sv: directed tests over apb and lookup tasks.
// assumes: walker model answers walks; 100 MHz clock, reset held 16 cycles.
`timescale 1ns/1ns
`include "tlbc_map.svh"
module translation_lookaside_buffer_tb
    import tlbc_pkg::*;
;
    localparam logic [47:0] OFS = 48'h0100_0000_0000;
    localparam tlbc_gran_t  GRAN [4] = '{TLBC_GR_4K, TLBC_GR_16K, TLBC_GR_16K, TLBC_GR_64K};
    localparam logic [1:0]  LVL [4]  = '{2'd3, 2'd3, 2'd2, 2'd3};
    localparam logic [47:0] SPAN [4] = '{48'h0000_0001_0000, 48'h0000_0020_0000,
                                         48'h0000_4000_0000, 48'h0000_0020_0000};
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic        lkp_req, lkp_ack, lkp_fault, lkp_hit, walk_req, walk_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [47:0] lkp_va, lkp_pa, walk_va, base;
    logic [15:0] lkp_address_space_identifier;
    logic [1:0]  lkp_el, lkp_perm;
    logic [7:0]  lkp_attr, dly;
    tlbc_walk_t  walk_res, cfg;
    int          fails, samples_checked;

    tlbc_top #(.ENTRIES(16)) dut (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lkp_req(lkp_req), .lkp_va(lkp_va), .lkp_address_space_identifier(lkp_address_space_identifier), .lkp_el(lkp_el),
        .lkp_ack(lkp_ack), .lkp_pa(lkp_pa), .lkp_attr(lkp_attr), .lkp_perm(lkp_perm),
        .lkp_fault(lkp_fault), .lkp_hit(lkp_hit), .walk_req(walk_req), .walk_va(walk_va),
        .walk_done(walk_done), .walk_res(walk_res)
    );
    tlbc_walker u_walk (
        .clk(clk), .nrst(nrst), .walk_req(walk_req), .walk_va(walk_va), .dly(dly),
        .cfg(cfg), .walk_done(walk_done), .walk_res(walk_res)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task results;
        $display("checks=%0d errors=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    task chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task lkp(input logic [47:0] va, input logic [15:0] address_space_identifier, input logic hit, input logic flt);
        @(posedge clk);
        lkp_req  <= 1'b1;
        lkp_va   <= va;
        lkp_address_space_identifier <= address_space_identifier;
        lkp_el   <= 2'd1;
        @(posedge clk);
        while (lkp_ack !== 1'b1) begin
            @(posedge clk);
        end
        chk(48'(lkp_hit), 48'(hit));
        chk(48'(lkp_fault), 48'(flt));
        if (!flt) begin
            chk(lkp_pa, va + OFS);
            chk(48'({lkp_attr, lkp_perm}), 48'({8'hA5, 2'b10}));
        end
        lkp_req <= 1'b0;
    endtask : lkp

    // stale entry removed or kept by command
    // fill one entry, invalidate, then look again
    task inv(input logic [7:0] n, input logic [7:0] cmd, input logic [15:0] hi, input logic keep);
        logic [47:0] va;
        va = {16'h0001, n, 24'h00_0000};
        lkp(va, 16'h0001, 1'b0, 1'b0);
        apb(1'b1, `TLBC_OPERAND_OFF, va[31:0]);
        apb(1'b1, `TLBC_OPERAND_HI, {16'h0000, hi});
        apb(1'b1, `TLBC_INVCMD_OFF, {24'h00_0000, cmd});
        lkp(va, 16'h0001, keep, 1'b0);
    endtask : inv

    initial begin
        #200_000;
        fails++;
        results();
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        lkp_req = 1'b0;
        lkp_va = '0;
        lkp_address_space_identifier = 16'h0000;
        lkp_el = 2'd0;
        cfg = '0;
        cfg.level = 2'd3;
        cfg.mem_attr = 8'hA5;
        cfg.perm = 2'b10;
        cfg.inner_sh = 1'b1;
        dly = 8'd20;
        fails = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `TLBC_CTRL_OFF, 32'h0000_0000);
        chk(48'(rd), 48'h1);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(48'(rd), 48'h0);
        cfg.fault = 1'b1;
        lkp(48'h0002_0000_3000, 16'h0001, 1'b0, 1'b1);
        lkp(48'h0002_0000_3000, 16'h0001, 1'b0, 1'b1);
        apb(1'b0, `TLBC_MISSCNT_OFF, 32'h0000_0000);
        chk(48'(rd), 48'h2);
        cfg.fault = 1'b0;
        dly = 8'd1;
        lkp(48'h0002_0000_5000, 16'h0001, 1'b0, 1'b0);
        lkp(48'h0002_0000_5abc, 16'h0001, 1'b1, 1'b0);
        inv(8'h01, 8'h20, 16'h0001, 1'b1);
        inv(8'h02, 8'h30, 16'h0001, 1'b1);
        inv(8'h03, 8'h10, 16'h0001, 1'b0);
        inv(8'h04, 8'h11, 16'h0002, 1'b1);
        inv(8'h05, 8'h11, 16'h0001, 1'b0);
        inv(8'h06, 8'h12, 16'h0002, 1'b1);
        inv(8'h07, 8'h12, 16'h0001, 1'b0);
        lkp(48'h0001_0800_0000, 16'h0007, 1'b0, 1'b0);
        apb(1'b1, `TLBC_OPERAND_OFF, 32'h0800_0000);
        apb(1'b1, `TLBC_OPERAND_HI, 32'h0000_0001);
        apb(1'b1, `TLBC_INVCMD_OFF, 32'h0000_0012);
        lkp(48'h0001_0800_0000, 16'h0007, 1'b1, 1'b0);
        apb(1'b1, `TLBC_INVCMD_OFF, 32'h0000_0013);
        lkp(48'h0001_0800_0000, 16'h0007, 1'b0, 1'b0);
        inv(8'h09, 8'h14, 16'h0001, 1'b0);
        inv(8'h0A, 8'h15, 16'h0001, 1'b0);
        inv(8'h0B, 8'h16, 16'h0001, 1'b1);
        inv(8'h0C, 8'h92, 16'h0001, 1'b0);
        cfg.inner_sh = 1'b0;
        inv(8'h0D, 8'h50, 16'h0001, 1'b1);
        cfg.inner_sh = 1'b1;
        inv(8'h0E, 8'h50, 16'h0001, 1'b0);
        cfg.level = 2'd2;
        cfg.block = 1'b0;
        inv(8'h0F, 8'h92, 16'h0001, 1'b1);
        cfg.contig = 1'b1;
        for (int k = 0; k < 4; k++) begin
            cfg.gran = GRAN[k];
            cfg.level = LVL[k];
            cfg.block = (LVL[k] == 2'd2);
            base = 48'h0010_0000_0000 + 48'(k) * 48'h0000_8000_0000;
            lkp(base, 16'h0003, 1'b0, 1'b0);
            lkp(base + SPAN[k] - 48'h1000, 16'h0003, 1'b1, 1'b0);
            lkp(base + SPAN[k], 16'h0003, 1'b0, 1'b0);
        end
        results();
    end
endmodule : translation_lookaside_buffer_tb
